// ---- pet_pkg.sv ----
// Package for the program, external, float-unavailable and trace entry unit
package pet_pkg;
  // Machine state and state save bit positions (bit 0 is the most significant, big-endian)
  localparam int MS_EE = 16;
  localparam int MS_PR = 17;
  localparam int MS_FP = 18;
  localparam int MS_ME = 19;
  localparam int MS_FE = 20;
  localparam int MS_SE = 21;
  localparam int MS_BE = 22;
  localparam int MS_B23 = 23;
  localparam int MS_AL = 24;
  localparam int MS_IP = 25;
  localparam int MS_IR = 26;
  localparam int MS_DR = 27;
  localparam int MS_PM = 29;
  localparam int SS_FPE = 11;
  localparam int SS_INV = 12;
  localparam int SS_PRV = 13;
  localparam int SS_TRP = 14;

  // Vector offsets and bases
  localparam logic [31:0] VEC_PROGRAM = 32'h0000_0700;
  localparam logic [31:0] VEC_EXTERNAL = 32'h0000_0500;
  localparam logic [31:0] VEC_FPUNAVAIL = 32'h0000_0800;
  localparam logic [31:0] VEC_TRACE = 32'h0000_0A00;
  localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hFFF0_0000;

  // Register indices and reset values
  localparam logic [1:0] REG_RET_ADDR = 2'h0;
  localparam logic [1:0] REG_STATE_SAVE = 2'h1;
  localparam logic [1:0] REG_MACHINE = 2'h2;
  localparam logic [1:0] REG_FLOAT_STAT = 2'h3;
  localparam logic [31:0] MS_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // Instruction completing in the pipeline this cycle
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic undefined_op;
    logic privileged;
    logic float_op;
    logic float_enabled_exc;
    logic float_stat_sets_exc;
    logic trap_taken;
  } pet_instr_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pet_bus_t;

  typedef enum logic [2:0] {
    ENT_NONE, ENT_PROGRAM, ENT_EXTERNAL, ENT_FPUNAVAIL, ENT_TRACE
  } pet_entry_t;

  // Big-endian bit index to little-endian vector position
  function automatic int be(input int b);
    return 31 - b;
  endfunction : be
endpackage : pet_pkg

// ---- pet_entry_unit.sv ----
// Interrupt entry unit: program, external, float-unavailable, trace
// ----------------------------------------------------------------------
// Summary of operation
// RULE1 - Float-enabled program interrupt when exception enable and summary both set.
// RULE2 - Summary set by enabled float exception or status write setting flag+enable.
// RULE3 - Undefined opcode or opcode pairing raises invalid-operation program interrupt.
// RULE4 - Privileged instruction in user mode raises privileged program interrupt.
// RULE5 - Trap instruction with a true condition raises trap program interrupt.
// RULE6 - Program interrupt saves faulting instruction address as return address.
// RULE7 - Program cause lands in state save bits 11-14; bits 0-10,15 cleared.
// RULE8 - State save lower half copies machine state; others clear upper half.
// RULE9 - Entry clears enable, mode, relocate bits; keeps machine-check and prefix.
// RULE10 - Program entry vectors to offset 0x700 from prefix-selected base.
// RULE11 - Setting enable with summary pending interrupts, saving next address.
// RULE12 - External interrupt taken only while request present and enable set.
// RULE13 - External entry saves address that would have executed next.
// RULE14 - External entry vectors to offset 0x500 from prefix-selected base.
// RULE15 - Float instruction with float unavailable raises float-unavailable interrupt.
// RULE16 - Float-unavailable entry saves faulting float instruction address.
// RULE17 - Float-unavailable entry vectors to offset 0x800.
// RULE18 - Trace interrupt after each instruction completing without other interrupt.
// RULE19 - Trace entry saves next sequential or taken branch target address.
// RULE20 - Trace entry also clears single-step, branch-trace, bit 23, monitor mark.
// RULE21 - Trace entry vectors to offset 0xA00.
// RULE22 - Trace only while single-step or branch-trace enable is set.
// RULE23 - Only one program cause recorded per entry.
// ----------------------------------------------------------------------
module pet_entry_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire pet_pkg::pet_instr_t instr_i,
  input wire logic ext_req_i,
  input wire pet_pkg::pet_bus_t bus_i,
  output logic [31:0] rdata_o,
  output logic take_o,
  output logic [31:0] vector_o,
  output logic [31:0] machine_state_o
);
  import pet_pkg::*;

  logic [31:0] return_address_save_reg;
  logic [31:0] interrupt_state_save_reg;
  logic [31:0] machine_state_word_reg;
  logic [31:0] float_status_control_reg;
  logic [31:0] machine_state_next;
  logic [31:0] fsc_next;
  logic [31:0] ret_next;
  logic [31:0] save_next;
  logic [31:0] vec_off;
  pet_entry_t entry;
  logic fex_now;
  logic prog_fpe;
  logic prog_inv;
  logic prog_prv;
  logic prog_trp;
  logic prog_late;
  logic ms_write;

  // Register write strobe aimed at one register index
  function automatic logic bus_hit(input pet_bus_t b, input logic [1:0] a);
    return b.wr && (b.addr == a);
  endfunction : bus_hit

  // ----------------------------------------------------------------------
  // Cause detection
  // ----------------------------------------------------------------------
  assign ms_write = bus_hit(bus_i, REG_MACHINE);
  // Summary raised by the completing instruction counts at once
  assign fex_now = float_status_control_reg[be(0)]
                   || (instr_i.valid && (instr_i.float_enabled_exc
                   || instr_i.float_stat_sets_exc)); // [RULE1] [RULE2]

  always_comb begin
    prog_inv = instr_i.valid && instr_i.undefined_op; // [RULE3]
    prog_prv = instr_i.valid && instr_i.privileged
               && machine_state_word_reg[be(MS_PR)]; // [RULE4]
    prog_trp = instr_i.valid && instr_i.trap_taken; // [RULE5]
    prog_fpe = machine_state_word_reg[be(MS_FE)] && fex_now; // [RULE1]
    // Pending summary exposed by a state write that left enable set
    prog_late = 1'b0;
    entry = ENT_NONE;
    if (prog_fpe || prog_inv || prog_prv || prog_trp) begin
      entry = ENT_PROGRAM;
      prog_late = prog_fpe && !prog_inv && !prog_prv && !prog_trp
                  && !instr_i.valid; // [RULE11]
    end else if (instr_i.valid && instr_i.float_op
                 && !machine_state_word_reg[be(MS_FP)]) begin
      entry = ENT_FPUNAVAIL; // [RULE15]
    end else if (ext_req_i && machine_state_word_reg[be(MS_EE)]) begin
      entry = ENT_EXTERNAL; // [RULE12]
    end else if (instr_i.valid && (machine_state_word_reg[be(MS_SE)]
                 || machine_state_word_reg[be(MS_BE)])) begin
      entry = ENT_TRACE; // [RULE18] [RULE22]
    end
  end

  // ----------------------------------------------------------------------
  // Saved state and vector selection
  // ----------------------------------------------------------------------
  always_comb begin
    ret_next = return_address_save_reg;
    save_next = interrupt_state_save_reg;
    vec_off = VEC_PROGRAM;
    machine_state_next = machine_state_word_reg;
    if (entry != ENT_NONE) begin
      save_next = {ZERO16, machine_state_word_reg[15:0]}; // [RULE8]
      machine_state_next[be(MS_EE)] = 1'b0; // [RULE9]
      machine_state_next[be(MS_PR)] = 1'b0;
      machine_state_next[be(MS_FP)] = 1'b0;
      machine_state_next[be(MS_FE)] = 1'b0;
      machine_state_next[be(MS_AL)] = 1'b0;
      machine_state_next[be(MS_IR)] = 1'b0;
      machine_state_next[be(MS_DR)] = 1'b0;
    end
    case (entry)
      ENT_PROGRAM: begin
        ret_next = prog_late ? return_address_save_reg : instr_i.addr; // [RULE6]
        if (prog_late) begin
          ret_next = instr_i.next_addr; // [RULE11]
        end
        // Priority encode so one cause bit is set
        if (prog_inv) begin
          save_next[be(SS_INV)] = 1'b1; // [RULE7] [RULE23]
        end else if (prog_prv) begin
          save_next[be(SS_PRV)] = 1'b1; // [RULE7] [RULE23]
        end else if (prog_trp) begin
          save_next[be(SS_TRP)] = 1'b1; // [RULE7] [RULE23]
        end else begin
          save_next[be(SS_FPE)] = 1'b1; // [RULE7] [RULE23]
        end
        vec_off = VEC_PROGRAM; // [RULE10]
      end
      ENT_EXTERNAL: begin
        ret_next = instr_i.valid ? instr_i.next_addr : instr_i.addr; // [RULE13]
        vec_off = VEC_EXTERNAL; // [RULE14]
      end
      ENT_FPUNAVAIL: begin
        ret_next = instr_i.addr; // [RULE16]
        vec_off = VEC_FPUNAVAIL; // [RULE17]
      end
      ENT_TRACE: begin
        ret_next = instr_i.next_addr; // [RULE19]
        machine_state_next[be(MS_SE)] = 1'b0; // [RULE20]
        machine_state_next[be(MS_BE)] = 1'b0;
        machine_state_next[be(MS_B23)] = 1'b0;
        machine_state_next[be(MS_PM)] = 1'b0;
        vec_off = VEC_TRACE; // [RULE21]
      end
      default: begin
        if (ms_write) begin
          machine_state_next = bus_i.wdata;
        end
      end
    endcase
  end

  // Summary bit follows float exceptions and status writes
  always_comb begin
    fsc_next = float_status_control_reg;
    if (bus_hit(bus_i, REG_FLOAT_STAT)) begin
      fsc_next = bus_i.wdata;
    end
    if (instr_i.valid && (instr_i.float_enabled_exc
        || instr_i.float_stat_sets_exc)) begin
      fsc_next[be(0)] = 1'b1; // [RULE2]
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      machine_state_word_reg <= MS_RESET;
    end else if (ce_i) begin
      machine_state_word_reg <= machine_state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      float_status_control_reg <= ZERO32;
    end else if (ce_i) begin
      float_status_control_reg <= fsc_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      return_address_save_reg <= ZERO32;
      interrupt_state_save_reg <= ZERO32;
    end else if (ce_i) begin
      if (entry != ENT_NONE) begin
        return_address_save_reg <= ret_next;
        interrupt_state_save_reg <= save_next;
      end else if (bus_hit(bus_i, REG_RET_ADDR)) begin
        return_address_save_reg <= bus_i.wdata;
      end else if (bus_hit(bus_i, REG_STATE_SAVE)) begin
        interrupt_state_save_reg <= bus_i.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_o <= 1'b0;
      vector_o <= ZERO32;
    end else if (ce_i) begin
      take_o <= (entry != ENT_NONE);
      vector_o <= (machine_state_word_reg[be(MS_IP)] ? VEC_BASE_HIGH
                   : VEC_BASE_LOW) | vec_off; // [RULE10]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      machine_state_o <= MS_RESET;
    end else if (ce_i) begin
      machine_state_o <= machine_state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= ZERO32;
    end else if (ce_i) begin
      rdata_o <= ZERO32;
      if (bus_i.rd) begin
        case (bus_i.addr)
          REG_RET_ADDR: rdata_o <= return_address_save_reg;
          REG_STATE_SAVE: rdata_o <= interrupt_state_save_reg;
          REG_MACHINE: rdata_o <= machine_state_word_reg;
          REG_FLOAT_STAT: rdata_o <= float_status_control_reg;
          default: rdata_o <= ZERO32;
        endcase
      end
    end
  end
endmodule : pet_entry_unit

// ---- pet_entry_unit_assertions.sv ----
// Port checker for the interrupt entry unit
module pet_entry_unit_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire pet_pkg::pet_instr_t instr_i,
  input wire logic ext_req_i,
  input wire pet_pkg::pet_bus_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic take_o,
  input wire logic [31:0] vector_o,
  input wire logic [31:0] machine_state_o
);
  import pet_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] ms;
  assign ms = machine_state_o;

  a_vec_base: assert property (
    take_o |-> vector_o[31:12] == (ms[6] ? 20'hF_FF00 : 20'h0_0000))
    else $error("entry vector base wrong");
  a_entry_clear: assert property (
    take_o |-> (ms & 32'h0000_E8B0) == 32'h0000_0000)
    else $error("entry left state bits set");
  a_inv_take: assert property (
    ce_i && instr_i.valid && instr_i.undefined_op
    |=> take_o && vector_o[11:0] == 12'h700)
    else $error("undefined opcode not taken");
  a_fpu_take: assert property (
    ce_i && instr_i.valid && instr_i.float_op && !ms[13] && !ms[11]
    && !instr_i.undefined_op && !instr_i.trap_taken
    && !(instr_i.privileged && ms[14])
    |=> take_o && vector_o[11:0] == 12'h800)
    else $error("float unavailable not taken");
  a_ext_take: assert property (
    ce_i && ext_req_i && ms[15] && !instr_i.valid && !ms[11]
    |=> take_o && vector_o[11:0] == 12'h500)
    else $error("external request not taken");
  a_ext_mask: assert property (
    ce_i && !ms[15] && !instr_i.valid && !ms[11] |=> !take_o)
    else $error("entry without a cause");
  a_no_trace: assert property (
    ce_i && instr_i.valid && instr_i[5:0] == 6'h00 && !ms[10] && !ms[9]
    && !ext_req_i && !ms[11] |=> !take_o)
    else $error("trace entry while tracing off");
  a_rd_idle: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule : pet_entry_unit_assertions

bind pet_entry_unit pet_entry_unit_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_i(instr_i),
  .ext_req_i(ext_req_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .take_o(take_o), .vector_o(vector_o),
  .machine_state_o(machine_state_o));

// ---- pet_ext_model.sv ----
// External requester: holds its level until the entry is taken
module pet_ext_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raise_i,
  input wire logic take_i,
  input wire logic [31:0] vector_i,
  output logic ext_req_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_req_o <= 1'b0;
    end else if (raise_i) begin
      ext_req_o <= 1'b1;
    end else if (take_i && vector_i[11:0] == 12'h500) begin
      ext_req_o <= 1'b0;
    end
  end
endmodule : pet_ext_model

// ---- tb_top.sv ----
// Self-checking bench for the interrupt entry unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pet_pkg::*;
  typedef struct {
    logic [5:0] q;
    logic [31:0] ms;
    logic [31:0] off;
    logic [3:0] c;
    logic nxt;
  } pet_row_t;
  localparam logic [31:0] A = 32'h0000_2000;
  localparam logic [31:0] N = 32'h0000_2004;
  localparam pet_instr_t IDLE = {1'b0, A, N, 6'h00};
  logic clk_i, rst_i, ce_i, ext_req_i, take_o, raise, t;
  logic [31:0] rdata_o, vector_o, machine_state_o, v;
  pet_instr_t instr_i;
  pet_bus_t bus_i;
  int fails, checks_done, cycles;
  pet_row_t rows [9];

  pet_ext_model u_ext (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
    .take_i(take_o), .vector_i(vector_o), .ext_req_o(ext_req_i));
  pet_entry_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .instr_i(instr_i), .ext_req_i(ext_req_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .take_o(take_o), .vector_o(vector_o),
    .machine_state_o(machine_state_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i <= {a, d, 2'h2};
    @(posedge clk_i);
    bus_i <= '0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus_i <= {a, ZERO32, 2'h1};
    @(posedge clk_i);
    bus_i <= '0;
    #1 d = rdata_o;
  endtask : rd

  task automatic wait_take(input int n, output logic f);
    f = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (take_o === 1'b1) begin
        f = 1'b1;
        break;
      end
    end
  endtask : wait_take

  // Entry outcome: vector, state word, both save registers
  task automatic ent(input logic [31:0] off, input logic [31:0] ms,
      input logic [31:0] ra, input logic [3:0] c);
    logic [31:0] d;
    chk(vector_o, (ms[6] ? VEC_BASE_HIGH : VEC_BASE_LOW) | off);
    chk(machine_state_o & 32'h0000_FFF4, ms & 32'h0000_1040);
    rd(REG_RET_ADDR, d);
    chk(d, ra);
    rd(REG_STATE_SAVE, d);
    chk(d, {11'h000, c, 1'b0, ms[15:0]});
  endtask : ent

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    raise = 1'b0;
    instr_i = IDLE;
    bus_i = '0;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    rows = '{'{6'h20, 32'h0000_2000, VEC_PROGRAM, 4'h4, 1'b0},
      '{6'h10, 32'h0000_6040, VEC_PROGRAM, 4'h2, 1'b0},
      '{6'h01, 32'h0000_2000, VEC_PROGRAM, 4'h1, 1'b0},
      '{6'h0C, 32'h0000_2800, VEC_PROGRAM, 4'h8, 1'b0},
      '{6'h31, 32'h0000_6000, VEC_PROGRAM, 4'h4, 1'b0},
      '{6'h08, 32'h0000_1040, VEC_FPUNAVAIL, 4'h0, 1'b0},
      '{6'h00, 32'h0000_2704, VEC_TRACE, 4'h0, 1'b1},
      '{6'h00, 32'h0000_2000, ZERO32, 4'h0, 1'b0},
      '{6'h10, 32'h0000_2000, ZERO32, 4'h0, 1'b0}};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_MACHINE, v);
    chk(v, MS_RESET);
    for (int k = 0; k < 9; k++) begin
      wr(REG_FLOAT_STAT, ZERO32);
      wr(REG_MACHINE, rows[k].ms);
      @(posedge clk_i);
      instr_i <= {1'b1, A, N, rows[k].q};
      @(posedge clk_i);
      instr_i <= IDLE;
      #1;
      chk(32'(take_o), 32'(rows[k].off != ZERO32));
      if (rows[k].off != ZERO32) begin
        ent(rows[k].off, rows[k].ms, rows[k].nxt ? N : A, rows[k].c);
      end
      $display("row %0d done", k);
    end
    @(posedge clk_i);
    raise <= 1'b1;
    @(posedge clk_i);
    raise <= 1'b0;
    wr(REG_MACHINE, 32'h0000_2040);
    wait_take(4, t);
    chk(32'(t), ZERO32);
    wr(REG_MACHINE, 32'h0000_A040);
    wait_take(4, t);
    chk(32'(t), 32'h0000_0001);
    ent(VEC_EXTERNAL, 32'h0000_A040, A, 4'h0);
    $display("external test done");
    wr(REG_MACHINE, 32'h0000_2000);
    @(posedge clk_i);
    instr_i <= {1'b1, A, N, 6'h0A};
    @(posedge clk_i);
    instr_i <= IDLE;
    wait_take(3, t);
    chk(32'(t), ZERO32);
    wr(REG_MACHINE, 32'h0000_2800);
    wait_take(4, t);
    chk(32'(t), 32'h0000_0001);
    ent(VEC_PROGRAM, 32'h0000_2800, N, 4'h8);
    $display("pending enable test done");
    tally_and_finish();
  end
endmodule : tb_top
